// [design/abe_analog_enable.sv]
// AHB-Lite register bank gating the analog control functions
// What this block does
// - Bypass bit skips low-side dead-time delay
// - Bit 3 drives negative sense pull-down
// - Bit 2 drives positive sense pull-up
// - Bit 1 enables undervoltage accelerator
// - Enabled accelerator fault forces both drives low while its detector is on
// - Bit 0 enables overvoltage accelerator
// - Overvoltage detect off ignores its threshold
// - Undervoltage detect off ignores its threshold
// - Writing start bit begins efficiency measurement
// - Slope bypass bit bypasses slope compensation
// - Current bit enables peak current measurement
// - Temperature sensing active only while bit set
// - Efficiency enable bit powers efficiency circuitry
// - Signal chain bit enables voltage control path
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module abe_analog_enable (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Analog fault comparators, asynchronous
  input  wire logic                ov_fault_raw,
  input  wire logic                uv_fault_raw,
  // Gate requests from the modulator, same clock
  input  wire logic                high_drive_req,
  input  wire logic                low_drive_req,
  input  wire logic [7:0]          low_dead_cycles,
  // Gate outputs and analog controls
  output logic                     high_gate_drive,
  output logic                     low_gate_drive,
  output logic                     eff_measure_start,
  output abe_pkg::abe_ctrl_t       ctrl
);

  localparam int NREG = 5;

  // Map a byte address to a register index
  function automatic logic [2:0] addr_idx(input logic [7:0] a);
    unique case (a)
      abe_pkg::ADDR_PERIPH_EN1: addr_idx = 3'd0;
      abe_pkg::ADDR_BLOCK_EN:   addr_idx = 3'd1;
      abe_pkg::ADDR_OV_THRESH:  addr_idx = 3'd2;
      abe_pkg::ADDR_UV_THRESH:  addr_idx = 3'd3;
      abe_pkg::ADDR_STATUS:     addr_idx = 3'd4;
      default:                  addr_idx = 3'd7;
    endcase
  endfunction

  // Bus address-phase capture
  abe_pkg::abe_wr_t wr_q;
  abe_pkg::abe_wr_t wr_d;
  logic             rd_ph_q;
  logic             rd_ph_d;
  // Read aimed at the live status word
  logic             st_sel_q;
  logic             st_sel_d;
  logic             take;
  logic             wr_en;
  logic [2:0]       wr_idx;
  logic [2:0]       rd_idx;
  logic [7:0]       rd_byte;
  logic [7:0]       regs [NREG];
  logic [7:0]       wdata;

  // Fault synchronisers and gate state
  logic [1:0]       ov_sync_q;
  logic [1:0]       ov_sync_d;
  logic [1:0]       uv_sync_q;
  logic [1:0]       uv_sync_d;
  logic             hi_q;
  logic             hi_d;
  logic             lo_q;
  logic             lo_d;
  logic [7:0]       dly_q;
  logic [7:0]       dly_d;
  logic             start_q;
  logic             start_d;
  logic             shut;
  logic             ov_hit;
  logic             uv_hit;
  logic [7:0]       status;

  // Transfer accepted when selected, active and bus ready
  assign take = hsel && htrans[1] && hready;

  // Address phase capture for the following data phase
  always_comb begin
    wr_d.valid = take && hwrite;
    wr_d.addr  = haddr[7:0];
    rd_ph_d    = take && !hwrite;
    // Status slot in the file stays zero, so remember where the read went
    st_sel_d   = take && !hwrite &&
                 (haddr[7:0] == abe_pkg::ADDR_STATUS);
  end

  // Address-phase state, held for exactly one data phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q     <= '0;
      rd_ph_q  <= 1'b0;
      st_sel_q <= 1'b0;
    end else begin
      wr_q     <= wr_d;
      rd_ph_q  <= rd_ph_d;
      st_sel_q <= st_sel_d;
    end
  end

  // Write lands in data phase; read index taken in address phase
  assign wr_en  = wr_q.valid && (wr_q.addr != abe_pkg::ADDR_STATUS);
  assign wr_idx = addr_idx(wr_q.addr);
  assign wdata  = hwdata[7:0];
  assign rd_idx = addr_idx(haddr[7:0]);

  // Plain read/write storage, no side effects on read
  abe_regfile #(
    .NREG (NREG)
  ) u_regs (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wdata),
    .rd_idx  (rd_idx),
    .rd_data (rd_byte),
    .regs    (regs)
  );

  // Status view not stored in the file; live state instead
  assign status = {3'h0, start_q, ov_hit, uv_hit, hi_q, lo_q};

  // Zero-wait-state slave; upper bits read as zero
  always_comb begin
    hreadyout = 1'b1;
    hresp     = 1'b0;
    hrdata    = 32'h0000_0000;
    if (rd_ph_q && st_sel_q) begin
      // Live status, one cycle old; software polls it anyway
      hrdata = {24'h00_0000, status_q};
    end else if (rd_ph_q) begin
      hrdata = {24'h00_0000, rd_byte};
    end
  end

  // Status snapshot: registered so read data come from a flop
  // Stored slot in the file stays zero and is never read
  logic [7:0] status_q;
  logic [7:0] status_d;
  always_comb begin
    status_d = status;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 8'h00;
    end else begin
      status_q <= status_d;
    end
  end

  // Control decode from stored bytes
  always_comb begin
    // Bypass bit also steers the gate timing below
    ctrl.low_dead_time_bypass  = regs[0][abe_pkg::PE_LOW_DT_BYP];
    ctrl.neg_sense_pulldown_en = regs[0][abe_pkg::PE_NEG_PD];
    ctrl.pos_sense_pullup_en   = regs[0][abe_pkg::PE_POS_PU];
    ctrl.uv_accel_en           = regs[0][abe_pkg::PE_UV_ACCEL];
    ctrl.ov_accel_en           = regs[0][abe_pkg::PE_OV_ACCEL];
    ctrl.ov_detect_en          = regs[1][abe_pkg::BE_OV_DET];
    ctrl.uv_detect_en          = regs[1][abe_pkg::BE_UV_DET];
    ctrl.slope_comp_bypass     = regs[1][abe_pkg::BE_SLOPE_BYP];
    ctrl.current_meas_en       = regs[1][abe_pkg::BE_CUR_MEAS];
    ctrl.temp_sensor_en        = regs[1][abe_pkg::BE_TEMP_SENS];
    ctrl.eff_circuit_en        = regs[1][abe_pkg::BE_EFF_CIRC];
    ctrl.signal_chain_en       = regs[1][abe_pkg::BE_SIG_CHAIN];
    // Threshold ignored (reads as zero) while its detector is off
    ctrl.ov_threshold = ctrl.ov_detect_en ? regs[2] : 8'h00;
    ctrl.uv_threshold = ctrl.uv_detect_en ? regs[3] : 8'h00;
  end

  // Pin faults pass two flops before any logic
  always_comb begin
    ov_sync_d = {ov_sync_q[0], ov_fault_raw};
    uv_sync_d = {uv_sync_q[0], uv_fault_raw};
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_sync_q <= 2'b00;
      uv_sync_q <= 2'b00;
    end else begin
      ov_sync_q <= ov_sync_d;
      uv_sync_q <= uv_sync_d;
    end
  end

  // A fault counts only while its detector is on
  assign ov_hit = ctrl.ov_detect_en && ov_sync_q[1];
  assign uv_hit = ctrl.uv_detect_en && uv_sync_q[1];

  // Accelerator shutdown; combinational so it acts at once
  assign shut = (ctrl.ov_accel_en && ov_hit) ||
                (ctrl.uv_accel_en && uv_hit);

  // Gate timing: low-side turn-on delayed unless bypassed
  always_comb begin
    hi_d  = high_drive_req;
    lo_d  = lo_q;
    dly_d = dly_q;
    if (!low_drive_req) begin
      lo_d  = 1'b0;
      dly_d = 8'h00;
    end else if (!lo_q) begin
      if (ctrl.low_dead_time_bypass) begin
        lo_d = 1'b1;
      end else if (dly_q >= low_dead_cycles) begin
        lo_d = 1'b1;
      end else begin
        dly_d = dly_q + 8'h01;
      end
    end
    // Shutdown overrides modulator requests
    if (shut) begin
      hi_d  = 1'b0;
      lo_d  = 1'b0;
      dly_d = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_q  <= 1'b0;
      lo_q  <= 1'b0;
      dly_q <= 8'h00;
    end else begin
      hi_q  <= hi_d;
      lo_q  <= lo_d;
      dly_q <= dly_d;
    end
  end

  // Outputs gated by shut too, so no cycle of lag on a fault
  assign high_gate_drive = hi_q && !shut;
  assign low_gate_drive  = lo_q && !shut;

  // One-cycle start pulse on a block enable write with the start bit one
  always_comb begin
    start_d = wr_en && (wr_idx == 3'd1) &&
              wdata[abe_pkg::BE_MEAS_START];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_d;
    end
  end

  assign eff_measure_start = start_q;

endmodule

// [design/abe_pkg.sv]
// Package for the analog block enable register bank
package abe_pkg;

  // Register byte addresses on the bus
  localparam logic [7:0] ADDR_PERIPH_EN1  = 8'h00;
  localparam logic [7:0] ADDR_BLOCK_EN    = 8'h04;
  localparam logic [7:0] ADDR_OV_THRESH   = 8'h08;
  localparam logic [7:0] ADDR_UV_THRESH   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS      = 8'h10;

  // Values after reset
  localparam logic [7:0] RST_PERIPH_EN1   = 8'h00;
  localparam logic [7:0] RST_BLOCK_EN     = 8'h00;
  localparam logic [7:0] RST_THRESH       = 8'h00;

  // Peripheral enable one field positions
  localparam int PE_LOW_DT_BYP = 4;
  localparam int PE_NEG_PD     = 3;
  localparam int PE_POS_PU     = 2;
  localparam int PE_UV_ACCEL   = 1;
  localparam int PE_OV_ACCEL   = 0;

  // Block enable field positions
  localparam int BE_OV_DET     = 7;
  localparam int BE_UV_DET     = 6;
  localparam int BE_MEAS_START = 5;
  localparam int BE_SLOPE_BYP  = 4;
  localparam int BE_CUR_MEAS   = 3;
  localparam int BE_TEMP_SENS  = 2;
  localparam int BE_EFF_CIRC   = 1;
  localparam int BE_SIG_CHAIN  = 0;

  // Register select index width
  localparam int REG_IDX_W = 3;

  // Analog control outputs grouped
  typedef struct packed {
    logic       low_dead_time_bypass;
    logic       neg_sense_pulldown_en;
    logic       pos_sense_pullup_en;
    logic       uv_accel_en;
    logic       ov_accel_en;
    logic       ov_detect_en;
    logic       uv_detect_en;
    logic       slope_comp_bypass;
    logic       current_meas_en;
    logic       temp_sensor_en;
    logic       eff_circuit_en;
    logic       signal_chain_en;
    logic [7:0] ov_threshold;
    logic [7:0] uv_threshold;
  } abe_ctrl_t;

  // Pending bus write captured in address phase
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } abe_wr_t;

endpackage

// [design/abe_regfile.sv]
// Small register memory for the control bytes
`timescale 1ns/1ps
module abe_regfile #(
  parameter int NREG = 5
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic [2:0] rd_idx,
  output logic      [7:0] rd_data,
  output logic      [7:0] regs [NREG]
);

  // Storage next state
  logic [7:0] mem_d [NREG];
  logic [7:0] mem_q [NREG];
  logic [7:0] rd_d;
  logic [7:0] rd_q;

  // Write decode and registered read
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en && (int'(wr_idx) < NREG)) begin
      mem_d[wr_idx] = wr_data;
    end
    // Unmapped index reads zero
    rd_d = (int'(rd_idx) < NREG) ? mem_q[rd_idx] : 8'h00;
  end

  // Registers only; all clear at reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NREG; i++) begin
        mem_q[i] <= 8'h00;
      end
      rd_q <= 8'h00;
    end else begin
      mem_q <= mem_d;
      rd_q  <= rd_d;
    end
  end

  assign rd_data = rd_q;
  assign regs    = mem_q;

endmodule

// [tb/abe_analog_enable_assertions.sv]
// Port checks for the analog enable register bank
`timescale 1ns/1ps
module abe_analog_enable_assertions (
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [2:0]         hsize,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               ov_fault_raw,
  input wire logic               uv_fault_raw,
  input wire logic               high_drive_req,
  input wire logic               low_drive_req,
  input wire logic [7:0]         low_dead_cycles,
  input wire logic               high_gate_drive,
  input wire logic               low_gate_drive,
  input wire logic               eff_measure_start,
  input wire abe_pkg::abe_ctrl_t ctrl
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Fault held long enough to cross both sync flops
  sequence ov_armed;
    (ov_fault_raw && ctrl.ov_detect_en && ctrl.ov_accel_en)[*3];
  endsequence
  // Both comparators quiet, so no shutdown can be pending
  sequence calm;
    (!ov_fault_raw && !uv_fault_raw)[*3];
  endsequence
  // Write address phase aimed at the block enable word
  sequence be_write;
    hsel && htrans[1] && hready && hwrite && haddr == 32'h0000_0004;
  endsequence
  a_ov_shut_gates: assert property (
    ov_armed |-> !high_gate_drive && !low_gate_drive)
    else $error("gate left on during overvoltage");
  a_high_follow: assert property (
    calm |=> high_gate_drive == $past(high_drive_req))
    else $error("high gate does not follow request");
  a_low_fall: assert property (
    !low_drive_req |=> !low_gate_drive)
    else $error("low gate stays on after request drop");
  a_low_bypass: assert property (
    calm ##0 (ctrl.low_dead_time_bypass && low_drive_req)[*2]
    |=> low_gate_drive)
    else $error("low gate delayed while bypassed");
  a_start_cause: assert property (
    be_write ##1 hwdata[5] |=> eff_measure_start)
    else $error("no start pulse after start write");
  a_start_pulse: assert property (
    eff_measure_start |=> !eff_measure_start)
    else $error("start pulse longer than one cycle");
  a_ovth_ignored: assert property (
    !ctrl.ov_detect_en |-> ctrl.ov_threshold == 8'h00)
    else $error("ov threshold passed while detect off");
  a_uvth_ignored: assert property (
    !ctrl.uv_detect_en |-> ctrl.uv_threshold == 8'h00)
    else $error("uv threshold passed while detect off");
endmodule
bind abe_analog_enable abe_analog_enable_assertions u_chk (.*);

// [tb/abe_analog_enable_bench.sv]
// Self-checking bench for the analog enable register bank
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module abe_analog_enable_bench;
  logic        sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_q, r;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        ov_fault_raw = 1'b0, uv_fault_raw = 1'b0;
  logic        high_drive_req = 1'b0, low_drive_req = 1'b0;
  logic [7:0]  low_dead_cycles = 8'h03;
  logic        high_gate_drive, low_gate_drive, eff_measure_start;
  abe_pkg::abe_ctrl_t ctrl;
  int          num_errors = 0, n_tests = 0, k, pulses = 0;
  // Rows: address, write data, expected twelve control flags
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h04};
  logic [7:0]  wd [6] = '{8'h1f, 8'hdf, 8'he8, 8'h15, 8'h00, 8'h00};
  logic [11:0] ex [6] = '{12'hf80, 12'hfff, 12'h47f, 12'h415, 12'h015,
                          12'h000};
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #12.5 sys_clk = ~sys_clk;
  // Read data and start pulses taken at the edge
  always @(posedge sys_clk) rd_q <= hrdata;
  always @(posedge sys_clk) pulses <= pulses + int'(eff_measure_start);
  abe_analog_enable DUT (.*);
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  // Bounded wait for an edge with ready high
  task automatic edge_rdy();
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hready !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // One single transfer, entered just after an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    edge_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    edge_rdy();
    #1 r = rd_q;
    `CHK(hresp, 1'b0)
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog well past the expected run length
  initial begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    conclude();
  end
  initial begin
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    for (int i = 0; i < 16; i += 4) begin
      xfer(1'b0, 8'(i), 32'h0);
      `CHK(r, 32'h0)
    end
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, ra[i], {24'h0, wd[i]});
      tick(1);
      `CHK(ctrl[27:16], ex[i])
      xfer(1'b0, ra[i], 32'h0);
      `CHK(r, {24'h0, wd[i]})
    end
    $display("test table done");
    // Normal-operation enables kept set by software
    xfer(1'b1, 8'h04, 32'h1d);
    tick(1);
    `CHK(ctrl[20:16], 5'h1d)
    // Start bit gives one pulse and is also kept
    k = pulses;
    xfer(1'b1, 8'h04, 32'h20);
    tick(3);
    `CHK(pulses - k, 1)
    xfer(1'b0, 8'h04, 32'h0);
    `CHK(r, 32'h20)
    // Thresholds hidden until detection is on
    xfer(1'b1, 8'h08, 32'h5a);
    xfer(1'b1, 8'h0c, 32'ha5);
    tick(1);
    `CHK(ctrl[15:0], 16'h0)
    xfer(1'b1, 8'h04, 32'hc0);
    tick(1);
    `CHK(ctrl[15:0], 16'h5aa5)
    // Unmapped and status places ignore writes
    xfer(1'b1, 8'h14, 32'hff);
    xfer(1'b1, 8'h10, 32'hff);
    xfer(1'b0, 8'h14, 32'h0);
    `CHK(r, 32'h0)
    xfer(1'b0, 8'h10, 32'h0);
    `CHK(r, 32'h0)
    $display("test registers done");
    // Dead time of three cycles, then overvoltage shutdown
    xfer(1'b1, 8'h00, 32'h03);
    high_drive_req <= 1'b1;
    low_drive_req <= 1'b1;
    k = 0;
    while (low_gate_drive !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    `CHK(k, 4)
    ov_fault_raw <= 1'b1;
    tick(1);
    `CHK({high_gate_drive, low_gate_drive}, 2'b11)
    tick(1);
    `CHK({high_gate_drive, low_gate_drive}, 2'b00)
    tick(1);
    `CHK({high_gate_drive, low_gate_drive}, 2'b00)
    // Undervoltage ignored while its accelerator is off
    ov_fault_raw <= 1'b0;
    xfer(1'b1, 8'h00, 32'h11);
    uv_fault_raw <= 1'b1;
    tick(3);
    `CHK({high_gate_drive, low_gate_drive}, 2'b11)
    xfer(1'b1, 8'h00, 32'h02);
    tick(2);
    `CHK({high_gate_drive, low_gate_drive}, 2'b00)
    // Bypass makes the low gate follow in one edge
    uv_fault_raw <= 1'b0;
    low_drive_req <= 1'b0;
    xfer(1'b1, 8'h00, 32'h10);
    `CHK(low_gate_drive, 1'b0)
    low_drive_req <= 1'b1;
    tick(1);
    `CHK(low_gate_drive, 1'b1)
    tick(2);
    $display("test gates done");
    // Reset in mid-run clears everything
    rst_n <= 1'b0;
    tick(1);
    `CHK({ctrl, high_gate_drive, low_gate_drive}, 30'h0)
    rst_n <= 1'b1;
    tick(1);
    xfer(1'b0, 8'h04, 32'h0);
    `CHK(r, 32'h0)
    $display("test second reset done");
    conclude();
  end
endmodule
